//--- hdl/fsp_calls.sv
// Purpose: flash self-programming call sequencer with its own code memory
// Assumes: call strobe is one cycle, parameters stable with it
// Notes: byte program takes a timed delay, block and page erases walk one byte per cycle
module fsp_calls #(
    parameter int MEM_BYTES = 65536,
    parameter int PROG_CYC = fsp_pkg::BYTE_PROG_CYC,
    parameter logic [7:0] MAKER_CODE = 8'h11, // Arbitrary value
    parameter logic [7:0] DEVICE_CODE1 = 8'h22, // Arbitrary value
    parameter logic [7:0] DEVICE_CODE2 = 8'h33, // Arbitrary value
    parameter logic [7:0] LOADER_VERSION = 8'h01 // Arbitrary value
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic call_strobe,
    input wire logic [15:0] call_addr,
    input wire logic [7:0] function_code_register,
    input wire logic [7:0] address_high_byte,
    input wire logic [7:0] address_low_byte,
    input wire logic [7:0] result_in,
    output logic busy,
    output logic done,
    output logic [7:0] result_byte,
    output logic watchdog_timer_feed,
    output logic double_clock_flag,
    output logic status_bit_flag,
    output logic [2:0] security_bits,
    output logic [7:0] boot_vector
);
    typedef struct packed {
        fsp_pkg::fsp_state_type st;
        logic [15:0] ptr;
        logic [15:0] last;
        logic [15:0] cnt;
        logic [7:0] data;
        logic wr;
        logic done;
        logic feed;
        logic [7:0] res;
        logic dbl;
        logic stat;
        logic [2:0] sec;
        logic [7:0] bv;
    } fsp_calls_type;

    fsp_calls_type s_r;
    fsp_calls_type s_nxt;
    logic [7:0] mem [MEM_BYTES];
    logic [15:0] addr;
    logic [6:0] fn;
    logic [7:0] rd_byte;
    logic blk_hit;
    logic [2:0] blk_idx;
    logic call;

    assign addr = {address_high_byte, address_low_byte};
    assign fn = function_code_register[6:0]; // R2
    assign call = call_strobe && (call_addr == fsp_pkg::ENTRY_ADDR); // R1
    assign rd_byte = mem[addr];

    fsp_select #(
        .N(5),
        .CODES({fsp_pkg::BLK_48K, fsp_pkg::BLK_32K, fsp_pkg::BLK_16K, fsp_pkg::BLK_8K,
            fsp_pkg::SEL_0})
    ) u_blk (
        .sel(address_low_byte),
        .hit(blk_hit),
        .idx(blk_idx)
    );

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        s_nxt.feed = 1'b0;
        s_nxt.wr = 1'b0;
        unique case (s_r.st)
            fsp_pkg::ST_IDLE:
            begin
                if (call)
                begin
                    s_nxt.done = 1'b1;
                    s_nxt.feed = function_code_register[fsp_pkg::FEED_BIT]; // R2
                    s_nxt.res = fsp_pkg::STAT_PASS; // R5
                    unique case (fn)
                        fsp_pkg::FN_READ_ID: // R3
                        begin
                            unique case (address_low_byte)
                                fsp_pkg::SEL_0: s_nxt.res = MAKER_CODE;
                                fsp_pkg::SEL_1: s_nxt.res = DEVICE_CODE1;
                                fsp_pkg::SEL_2: s_nxt.res = DEVICE_CODE2;
                                fsp_pkg::SEL_3: s_nxt.res = {s_r.dbl, 7'h00};
                                fsp_pkg::SEL_VER: s_nxt.res = LOADER_VERSION;
                                default: s_nxt.res = fsp_pkg::STAT_FAIL;
                            endcase
                        end
                        fsp_pkg::FN_ERASE_BLOCK: // R4
                        begin
                            if (blk_hit)
                            begin
                                s_nxt.done = 1'b0;
                                s_nxt.st = fsp_pkg::ST_WIPE;
                                unique case (blk_idx)
                                    3'd0: s_nxt.ptr = 16'h0000;
                                    3'd1: s_nxt.ptr = 16'h2000;
                                    3'd2: s_nxt.ptr = 16'h4000;
                                    3'd3: s_nxt.ptr = 16'h8000;
                                    default: s_nxt.ptr = 16'hC000;
                                endcase
                                unique case (blk_idx)
                                    3'd0: s_nxt.last = 16'h1FFF;
                                    3'd1: s_nxt.last = 16'h3FFF;
                                    3'd2: s_nxt.last = 16'h7FFF;
                                    3'd3: s_nxt.last = 16'hBFFF;
                                    default: s_nxt.last = 16'hFFFF;
                                endcase
                            end
                            else
                            begin
                                s_nxt.res = fsp_pkg::STAT_FAIL; // R5
                            end
                        end
                        fsp_pkg::FN_PROG_BYTE: // R6
                        begin
                            s_nxt.done = 1'b0;
                            s_nxt.st = fsp_pkg::ST_BUSY;
                            s_nxt.ptr = addr;
                            s_nxt.data = result_in;
                            s_nxt.cnt = 16'(PROG_CYC);
                        end
                        fsp_pkg::FN_READ_BYTE: s_nxt.res = rd_byte; // R7
                        fsp_pkg::FN_ERASE_CFG: // R8
                        begin
                            s_nxt.stat = 1'b0;
                            s_nxt.bv = fsp_pkg::ERASED;
                        end
                        fsp_pkg::FN_PROG_SEC: // R9
                        begin
                            if (address_low_byte <= fsp_pkg::SEL_2)
                                s_nxt.sec[address_low_byte[1:0]] = 1'b1;
                            else
                                s_nxt.res = fsp_pkg::STAT_FAIL;
                        end
                        fsp_pkg::FN_PROG_CFG: // R10
                        begin
                            unique case (address_low_byte)
                                fsp_pkg::SEL_0: s_nxt.stat = 1'b1;
                                fsp_pkg::SEL_1: s_nxt.bv = result_in;
                                fsp_pkg::SEL_2: s_nxt.dbl = 1'b1;
                                default: s_nxt.res = fsp_pkg::STAT_FAIL;
                            endcase
                        end
                        fsp_pkg::FN_READ_CFG: // R11
                        begin
                            unique case (address_low_byte)
                                fsp_pkg::SEL_0: s_nxt.res = {5'h00, s_r.sec};
                                fsp_pkg::SEL_1: s_nxt.res = {5'h00, s_r.stat, 1'b0, s_r.dbl};
                                fsp_pkg::SEL_2: s_nxt.res = s_r.bv;
                                default: s_nxt.res = fsp_pkg::STAT_FAIL;
                            endcase
                        end
                        fsp_pkg::FN_ERASE_PAGE: // R12
                        begin
                            s_nxt.done = 1'b0;
                            s_nxt.st = fsp_pkg::ST_WIPE;
                            s_nxt.ptr = {addr[15:7], 7'h00}; // R13
                            s_nxt.last = {addr[15:7], 7'h7F}; // R13
                        end
                        default: s_nxt.res = fsp_pkg::STAT_FAIL; // R14
                    endcase
                end
            end
            fsp_pkg::ST_BUSY:
            begin
                if (s_r.cnt <= 16'h0001)
                begin
                    s_nxt.wr = 1'b1;
                    s_nxt.done = 1'b1;
                    s_nxt.st = fsp_pkg::ST_IDLE;
                end
                else
                    s_nxt.cnt = s_r.cnt - 16'h0001;
            end
            fsp_pkg::ST_WIPE:
            begin
                s_nxt.ptr = s_r.ptr + 16'h0001;
                if (s_r.ptr == s_r.last)
                begin
                    s_nxt.done = 1'b1;
                    s_nxt.st = fsp_pkg::ST_IDLE;
                end
            end
            default: s_nxt.st = fsp_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_r <= '0;
            s_r.bv <= fsp_pkg::BOOT_VEC_RST;
        end
        else
            s_r <= s_nxt;
    end

    always_ff @(posedge clk)
    begin
        if (s_r.st == fsp_pkg::ST_WIPE)
            mem[s_r.ptr] <= fsp_pkg::ERASED; // R4
        else if (s_nxt.wr)
            mem[s_r.ptr] <= s_r.data; // R6
    end

    assign busy = (s_r.st != fsp_pkg::ST_IDLE);
    assign done = s_r.done;
    assign result_byte = s_r.res;
    assign watchdog_timer_feed = s_r.feed;
    assign double_clock_flag = s_r.dbl;
    assign status_bit_flag = s_r.stat;
    assign security_bits = s_r.sec;
    assign boot_vector = s_r.bv;
endmodule : fsp_calls

//--- hdl/fsp_select.sv
// Purpose: decode a selector byte into a small index with a valid flag
// Assumes: selector values given as a constant table
// Notes: combinational
module fsp_select #(
    parameter int N = 3,
    parameter logic [8*N-1:0] CODES = '0
) (
    input wire logic [7:0] sel,
    output logic hit,
    output logic [2:0] idx
);
    always_comb
    begin
        hit = 1'b0;
        idx = 3'd0;
        for (int i = 0; i < N; i++)
        begin
            if (sel == CODES[8*i +: 8])
            begin
                hit = 1'b1;
                idx = 3'(i);
            end
        end
    end
endmodule : fsp_select

//--- pkg/fsp_pkg.sv
// Purpose: constants for the flash self-programming call sequencer
// Assumes: one 125 MHz clock, synchronous active-high reset
// Notes: function codes, selectors, timing
// How it works
// R1 - every request enters through one call strobe standing for the fixed entry address
// R2 - low seven bits pick the function; bit 7 set also feeds the watchdog
// R3 - read id: low byte picks maker, device codes, clock mode, or loader version
// R4 - block erase: low byte 00H,20H,40H,80H,C0H picks one of five blocks
// R5 - erase and program return zero on pass, nonzero on fail
// R6 - code 02H programs the result byte into memory at the high and low address
// R7 - code 03H returns the memory byte at the high and low address
// R8 - code 04H erases status bit and boot vector, ignoring both address bytes
// R9 - code 05H programs security bit 1, 2 or 3 by low byte 00H..02H
// R10 - code 06H programs status bit, boot vector from result byte, or clock mode
// R11 - code 07H reads security bits, status bit or boot vector by low byte
// R12 - code 08H erases the page at the high and low address
// R13 - a page erase clears exactly one 128-byte page, others untouched
// R14 - unknown code changes nothing and returns a nonzero failure status
package fsp_pkg;
    localparam logic [15:0] ENTRY_ADDR = 16'hFFF0;
    localparam logic [6:0] FN_READ_ID = 7'h00;
    localparam logic [6:0] FN_ERASE_BLOCK = 7'h01;
    localparam logic [6:0] FN_PROG_BYTE = 7'h02;
    localparam logic [6:0] FN_READ_BYTE = 7'h03;
    localparam logic [6:0] FN_ERASE_CFG = 7'h04;
    localparam logic [6:0] FN_PROG_SEC = 7'h05;
    localparam logic [6:0] FN_PROG_CFG = 7'h06;
    localparam logic [6:0] FN_READ_CFG = 7'h07;
    localparam logic [6:0] FN_ERASE_PAGE = 7'h08;
    localparam int FEED_BIT = 7;
    localparam logic [7:0] SEL_0 = 8'h00;
    localparam logic [7:0] SEL_1 = 8'h01;
    localparam logic [7:0] SEL_2 = 8'h02;
    localparam logic [7:0] SEL_3 = 8'h03;
    localparam logic [7:0] SEL_VER = 8'h80;
    localparam logic [7:0] BLK_8K = 8'h20;
    localparam logic [7:0] BLK_16K = 8'h40;
    localparam logic [7:0] BLK_32K = 8'h80;
    localparam logic [7:0] BLK_48K = 8'hC0;
    localparam logic [7:0] STAT_PASS = 8'h00;
    localparam logic [7:0] STAT_FAIL = 8'hFF;
    localparam logic [7:0] ERASED = 8'hFF;
    localparam int PAGE_BYTES = 128;
    localparam int CLK_MHZ = 125;
    localparam int BYTE_PROG_US = 1;
    localparam int BYTE_PROG_CYC = BYTE_PROG_US * CLK_MHZ;
    localparam logic [7:0] BOOT_VEC_RST = 8'hFC;
    typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_WIPE} fsp_state_type;
endpackage : fsp_pkg

//--- test/fsp_calls_props.sv
// Purpose: port checks for the call sequencer
// Assumes: one clock, synchronous active-high reset
// Notes: bound from the bench top
module fsp_calls_props #(
    parameter int PROG_CYC = fsp_pkg::BYTE_PROG_CYC,
    parameter logic [7:0] MAKER_CODE = 8'h11
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic call_strobe,
    input wire logic [15:0] call_addr,
    input wire logic [7:0] function_code_register,
    input wire logic [7:0] address_high_byte,
    input wire logic [7:0] address_low_byte,
    input wire logic [7:0] result_in,
    input wire logic busy,
    input wire logic done,
    input wire logic [7:0] result_byte,
    input wire logic watchdog_timer_feed,
    input wire logic double_clock_flag,
    input wire logic status_bit_flag,
    input wire logic [2:0] security_bits,
    input wire logic [7:0] boot_vector
);
    localparam int PLAT = PROG_CYC + 1;
    logic taken;
    logic [6:0] fn;
    assign taken = call_strobe && call_addr == 16'hFFF0 && !busy;
    assign fn = function_code_register[6:0];
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    chk_feed_when_set: assert property (
        taken && function_code_register[7] |=> watchdog_timer_feed)
        else $error("feed missing");
    chk_feed_cause: assert property (
        watchdog_timer_feed |-> $past(taken && function_code_register[7]))
        else $error("feed without request");
    chk_bad_entry: assert property (
        call_strobe && call_addr != 16'hFFF0 && !busy |=> !done)
        else $error("call at wrong entry answered");
    chk_maker_id: assert property (
        taken && fn == 7'h00 && address_low_byte == 8'h00 |=> done && result_byte == MAKER_CODE)
        else $error("maker code wrong");
    chk_prog_time: assert property (
        taken && fn == 7'h02 |-> ##PLAT done && result_byte == 8'h00)
        else $error("byte program answer wrong");
    chk_page_busy: assert property (
        taken && fn == 7'h08 |=> busy[*8] ##121 (done && !busy))
        else $error("page erase timing wrong");
    chk_erase_cfg: assert property (
        taken && fn == 7'h04 |=> done && result_byte == 8'h00 && !status_bit_flag
            && boot_vector == 8'hFF)
        else $error("config erase wrong");
    chk_bv_prog: assert property (
        taken && fn == 7'h06 && address_low_byte == 8'h01 |=> boot_vector == $past(result_in))
        else $error("boot vector not taken");
    chk_unknown_fail: assert property (
        taken && fn > 7'h08 |=> done && result_byte == 8'hFF)
        else $error("unknown code not refused");
    cov_page: cover property (taken && fn == 7'h08);
    cov_block: cover property (taken && fn == 7'h01);
    cov_prog: cover property (taken && fn == 7'h02);
    cov_feed: cover property (watchdog_timer_feed);
endmodule : fsp_calls_props

//--- test/fsp_host.sv
// Purpose: model of the calling software
// Assumes: strobe is one cycle, fields held until done
// Notes: entry may be moved to try a wrong address
module fsp_host (
    input wire logic clk,
    input wire logic done,
    input wire logic [7:0] result_byte,
    output logic call_strobe,
    output logic [15:0] call_addr,
    output logic [7:0] function_code_register,
    output logic [7:0] address_high_byte,
    output logic [7:0] address_low_byte,
    output logic [7:0] result_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] entry = 16'hFFF0;
    initial
    begin
        call_strobe = 1'b0;
        call_addr = 16'h0000;
        function_code_register = 8'h00;
        address_high_byte = 8'h00;
        address_low_byte = 8'h00;
        result_in = 8'h00;
    end
    task automatic call(input logic [7:0] f, h, l, a, input int n, output logic got,
                        output logic [7:0] r);
        got = 1'b0;
        r = 8'h00;
        @(posedge clk);
        #1;
        call_strobe = 1'b1;
        call_addr = entry;
        function_code_register = f;
        address_high_byte = h;
        address_low_byte = l;
        result_in = a;
        @(posedge clk);
        #1;
        call_strobe = 1'b0;
        for (int i = 0; i < n && !got; i++)
        begin
            got = (done === 1'b1);
            r = result_byte;
            if (!got)
            begin
                @(posedge clk);
                #1;
            end
        end
    endtask : call
endmodule : fsp_host

//--- test/tb_fsp_calls.sv
// Purpose: self-checking bench for the call sequencer
// Assumes: byte program shortened to 2 cycles
// Notes: random byte traffic plus fixed corner cases
module tb_fsp_calls;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, call_strobe, busy, done, feed, dbl, stat_flag, got;
    logic [15:0] call_addr, ad;
    logic [7:0] fc, hi, lo, ain, res, bv, r, d, w;
    logic [2:0] sec;
    logic [7:0] ids [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h80};
    logic [7:0] blk [5] = '{8'h00, 8'h20, 8'h40, 8'h80, 8'hC0};
    int errors, n_tests, cyc, seed;
    fsp_calls #(.PROG_CYC(2), .MAKER_CODE(8'h11), .DEVICE_CODE1(8'h22), .DEVICE_CODE2(8'h33),
        .LOADER_VERSION(8'h01)) u_dut (.clk(clk), .rst(rst), .call_strobe(call_strobe),
        .call_addr(call_addr), .function_code_register(fc), .address_high_byte(hi),
        .address_low_byte(lo), .result_in(ain), .busy(busy), .done(done), .result_byte(res),
        .watchdog_timer_feed(feed), .double_clock_flag(dbl), .status_bit_flag(stat_flag),
        .security_bits(sec), .boot_vector(bv));
    fsp_host u_host (.clk(clk), .done(done), .result_byte(res), .call_strobe(call_strobe),
        .call_addr(call_addr), .function_code_register(fc), .address_high_byte(hi),
        .address_low_byte(lo), .result_in(ain));
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    function automatic logic [7:0] exp_id(input logic [7:0] l, input logic k);
        case (l)
            8'h00: return 8'h11;
            8'h01: return 8'h22;
            8'h02: return 8'h33;
            8'h03: return {k, 7'h00};
            default: return 8'h01;
        endcase
    endfunction : exp_id
    task automatic check(input logic [7:0] g, e);
        n_tests++;
        if (g !== e)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : check
    task automatic run(input logic [7:0] f, h, l, a, e);
        u_host.call(f, h, l, a, 20000, got, r);
        check({7'h00, got}, 8'h01);
        check(r, e);
    endtask : run
    task automatic final_report();
        $display("tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            errors++;
            final_report();
        end
    end
    initial
    begin
        seed = 32'h7087_c8e0;
        rst = 1'b1;
        repeat (12) @(posedge clk);
        #1;
        rst = 1'b0;
        check(bv, 8'hFC);
        check({5'h00, sec}, 8'h00);
        for (int i = 0; i < 5; i++) run(8'h80, 8'h00, ids[i], 8'h00, exp_id(ids[i], 1'b0));
        for (int i = 0; i < 6; i++)
        begin
            ad = 16'($random(seed));
            d = 8'($random(seed));
            w = {$random(seed) % 2 == 0, 7'h00};
            run(w | 8'h02, ad[15:8], ad[7:0], d, 8'h00);
            run(w | 8'h03, ad[15:8], ad[7:0], 8'h00, d);
        end
        run(8'h02, 8'h34, 8'h7F, 8'h5A, 8'h00);
        run(8'h02, 8'h35, 8'h00, 8'hA5, 8'h00);
        run(8'h02, 8'h34, 8'hC3, 8'h3C, 8'h00);
        run(8'h88, 8'h34, 8'hC3, 8'h00, 8'h00);
        run(8'h03, 8'h34, 8'hC3, 8'h00, 8'hFF);
        run(8'h03, 8'h34, 8'h80, 8'h00, 8'hFF);
        run(8'h03, 8'h34, 8'h7F, 8'h00, 8'h5A);
        run(8'h03, 8'h35, 8'h00, 8'h00, 8'hA5);
        for (int i = 0; i < 5; i++)
        begin
            ad = {blk[i], 8'h00} - 16'h0001;
            run(8'h02, blk[i], 8'h00, 8'h11, 8'h00);
            run(8'h02, ad[15:8], ad[7:0], 8'h66, 8'h00);
            run(8'h01, 8'h00, blk[i], 8'h00, 8'h00);
            run(8'h03, blk[i], 8'h00, 8'h00, 8'hFF);
            run(8'h03, ad[15:8], ad[7:0], 8'h00, 8'h66);
        end
        run(8'h01, 8'h00, 8'h10, 8'h00, 8'hFF);
        run(8'h06, 8'h00, 8'h01, 8'h9C, 8'h00);
        check(bv, 8'h9C);
        run(8'h07, 8'h00, 8'h02, 8'h00, 8'h9C);
        run(8'h06, 8'h00, 8'h00, 8'h00, 8'h00);
        check({7'h00, stat_flag}, 8'h01);
        run(8'h86, 8'h00, 8'h02, 8'h00, 8'h00);
        check({7'h00, dbl}, 8'h01);
        run(8'h07, 8'h00, 8'h01, 8'h00, 8'h05);
        run(8'h00, 8'h00, 8'h03, 8'h00, exp_id(8'h03, 1'b1));
        for (int i = 0; i < 3; i++) run(8'h05, 8'h00, 8'(i), 8'h00, 8'h00);
        run(8'h85, 8'h00, 8'h03, 8'h00, 8'hFF);
        run(8'h07, 8'h00, 8'h00, 8'h00, 8'h07);
        check({5'h00, sec}, 8'h07);
        run(8'h04, 8'h5E, 8'hA7, 8'h00, 8'h00);
        check({7'h00, stat_flag}, 8'h00);
        check(bv, 8'hFF);
        run(8'h07, 8'h00, 8'h01, 8'h00, 8'h01);
        run(8'h87, 8'h00, 8'h02, 8'h00, 8'hFF);
        run(8'h09, 8'h00, 8'h00, 8'h00, 8'hFF);
        run(8'hFF, 8'h00, 8'h02, 8'h00, 8'hFF);
        run(8'h07, 8'h00, 8'h02, 8'h00, 8'hFF);
        u_host.entry = 16'hFFF1;
        u_host.call(8'h00, 8'h00, 8'h00, 8'h00, 4, got, r);
        check({7'h00, got}, 8'h00);
        u_host.entry = 16'hFFF0;
        final_report();
    end
endmodule : tb_fsp_calls
bind fsp_calls fsp_calls_props #(.PROG_CYC(PROG_CYC), .MAKER_CODE(MAKER_CODE)) u_props (
    .clk(clk), .rst(rst), .call_strobe(call_strobe), .call_addr(call_addr),
    .function_code_register(function_code_register), .address_high_byte(address_high_byte),
    .address_low_byte(address_low_byte), .result_in(result_in), .busy(busy), .done(done),
    .result_byte(result_byte), .watchdog_timer_feed(watchdog_timer_feed),
    .double_clock_flag(double_clock_flag), .status_bit_flag(status_bit_flag),
    .security_bits(security_bits), .boot_vector(boot_vector));
